// *** include/port_pin_override_params.svh ***
`ifndef PORT_PIN_OVERRIDE_PARAMS_SVH
`define PORT_PIN_OVERRIDE_PARAMS_SVH

// register byte offsets on the wishbone port
`define OFS_PIN_SAMPLE  8'h00
`define OFS_DIRECTION   8'h04
`define OFS_LATCH       8'h08
`define OFS_CONTROL     8'h0c
`define OFS_PC_MASK     8'h10
`define OFS_ANALOG_DIS  8'h14
`define OFS_OVR_STATUS  8'h18

// bus widths
`define WB_ADR_W        8
`define WB_DAT_W        32
`define WB_SEL_W        4

// control register field positions
`define CTRL_PUD_BIT    0
`define CTRL_PCIE_BIT   1

// per-bit reset values
`define RST_DIRECTION   1'b0
`define RST_LATCH       1'b0
`define RST_PUD         1'b0
`define RST_PCIE        1'b0
`define RST_PC_MASK     1'b0
`define RST_ANALOG_DIS  1'b0

// port width and pad synchroniser depth
`define PORT_WIDTH      8
`define SYNC_STAGES     3

`endif

// *** include/port_pin_override_pkg.sv ***
package port_pin_override_pkg;

   // register selected by a bus address
   typedef enum logic [2:0] {
      sel_pin    = 3'b000,
      sel_dir    = 3'b001,
      sel_latch  = 3'b010,
      sel_ctrl   = 3'b011,
      sel_pcmask = 3'b100,
      sel_adis   = 3'b101,
      sel_status = 3'b110,
      sel_none   = 3'b111
   } reg_sel_e;

endpackage

// *** verilog/pin_override_cell.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "port_pin_override_params.svh"

module pin_override_cell (
   input  wire logic clk_i,        // port clock
   input  wire logic rst_i,        // sync reset, active high
   input  wire logic ce_i,         // clock enable
   input  wire logic pad_in_i,     // raw pad level, asynchronous
   input  wire logic dir_bit_i,    // direction bit
   input  wire logic latch_bit_i,  // output latch bit
   input  wire logic pud_i,        // global pull-up disable
   input  wire logic sleep_i,      // deep sleep clamp request
   input  wire logic pu_en_i,      // pull-up override enable
   input  wire logic pu_val_i,     // pull-up override value
   input  wire logic dd_en_i,      // direction override enable
   input  wire logic dd_val_i,     // direction override value
   input  wire logic pv_en_i,      // value override enable
   input  wire logic pv_val_i,     // value override value
   input  wire logic ie_en_i,      // input-enable override enable
   input  wire logic ie_val_i,     // input-enable override value
   output logic      oe_o,         // resolved driver enable
   output logic      out_o,        // resolved driven value
   output logic      pu_o,         // resolved pull-up enable
   output logic      din_o,        // clamped digital input
   output logic      sample_o      // synchronised pin sample
);

   logic [`SYNC_STAGES-1:0] sync_reg;
   logic                    sample_reg;
   logic                    ie;

   // override resolution, pure gating on the pin
   always_comb begin
      oe_o  = dd_en_i ? dd_val_i : dir_bit_i;                      // [R3] [R4] [R15]
      out_o = oe_o & (pv_en_i ? pv_val_i : latch_bit_i);           // [R5] [R6]
      pu_o  = pu_en_i ? pu_val_i
                      : (~dir_bit_i & latch_bit_i & ~pud_i);       // [R1] [R2]
      ie    = ie_en_i ? ie_val_i : ~sleep_i;                       // [R8] [R9] [R16]
      din_o = pad_in_i & ie;                                       // [R10]
   end

   // three-stage pad synchroniser
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_reg <= '0;
      end else if (ce_i) begin
         sync_reg <= {sync_reg[`SYNC_STAGES-2:0], din_o};
      end
   end

   // sample only moves once the last two stages agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sample_reg <= 1'b0;
      end else if (ce_i && (sync_reg[`SYNC_STAGES-2] == sync_reg[`SYNC_STAGES-1])) begin
         sample_reg <= sync_reg[`SYNC_STAGES-1];
      end
   end

   assign sample_o = sample_reg;

endmodule
`default_nettype wire

// *** verilog/port_pin_override_mux.sv ***
// Functional notes
// R1 - pull-up override enable set: pull-up follows override value only
// R2 - otherwise pull-up on only when direction, latch, disable are 0,1,0
// R3 - direction override enable selects override value, else direction bit
// R4 - under direction override, driver on for value one, off for zero
// R5 - driven value from value override when enabled, else latch bit
// R6 - value override enable set: port value equals override value
// R7 - toggle override enable inverts that pin's output latch bit
// R8 - input-enable override selects override value, else sleep state decides
// R9 - under input-enable override, input on for one, off for zero
// R10 - modules get unsynchronised input after the clamp, and sync it themselves
// R11 - analog path goes straight from the pad, both ways; here analog_channel_in_o is a one-flop registered copy of pad_in_i, input only
// R12 - strobes shared per port, pull-up disable and sleep global, overrides per pin
// R13 - peripherals build their own override enables and values
// R14 - first port pin n is analog channel n and pin-change source n
// R15 - direction bit one makes an output, zero an input
// R16 - sleep clamps digital input unless an override keeps it enabled
// R17 - first port: pull-up, direction, value overrides off; input override from pin-change
// R18 - override enables held inactive during reset and until armed afterwards
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "port_pin_override_params.svh"

module port_pin_override_mux
   import port_pin_override_pkg::*;
#(
   parameter int  WIDTH      = `PORT_WIDTH,  // pins in this port
   parameter bit  FIRST_PORT = 1'b1          // first port mapping
) (
   input  wire logic                 clk_i,                   // port clock
   input  wire logic                 rst_i,                   // sync reset
   input  wire logic                 ce_i,                    // clock enable
   input  wire logic [`WB_ADR_W-1:0] adr_i,                   // wb address
   input  wire logic [`WB_DAT_W-1:0] dat_i,                   // wb write data
   output logic      [`WB_DAT_W-1:0] dat_o,                   // wb read data
   input  wire logic                 we_i,                    // wb write
   input  wire logic [`WB_SEL_W-1:0] sel_i,                   // wb byte lanes
   input  wire logic                 cyc_i,                   // wb cycle
   input  wire logic                 stb_i,                   // wb strobe
   output logic                      ack_o,                   // wb ack
   input  wire logic                 sleep_i,                 // deep sleep
   input  wire logic [WIDTH-1:0]     pad_in_i,                // pad levels
   output logic      [WIDTH-1:0]     pad_out_o,               // pad value
   output logic      [WIDTH-1:0]     pad_oe_o,                // pad drive
   output logic      [WIDTH-1:0]     pullup_en_o,             // pull-ups
   input  wire logic [WIDTH-1:0]     pullup_override_en_i,    // per pin
   input  wire logic [WIDTH-1:0]     pullup_override_val_i,   // per pin
   input  wire logic [WIDTH-1:0]     dir_override_en_i,       // per pin
   input  wire logic [WIDTH-1:0]     dir_override_val_i,      // per pin
   input  wire logic [WIDTH-1:0]     value_override_en_i,     // per pin
   input  wire logic [WIDTH-1:0]     value_override_val_i,    // per pin
   input  wire logic [WIDTH-1:0]     toggle_override_en_i,    // per pin
   input  wire logic [WIDTH-1:0]     input_en_override_en_i,  // per pin
   input  wire logic [WIDTH-1:0]     input_en_override_val_i, // per pin
   output logic      [WIDTH-1:0]     alt_digital_in_o,        // to modules
   output logic      [WIDTH-1:0]     analog_channel_in_o,     // pad copy
   output logic      [WIDTH-1:0]     pin_change_irq_src_o     // pc sources
);

   // software-visible state
   logic [WIDTH-1:0] direction_reg;
   logic [WIDTH-1:0] latch_reg;
   logic [WIDTH-1:0] latch_next;
   logic             global_pullup_disable_reg;
   logic             pin_change_group0_en_reg;
   logic [WIDTH-1:0] pc_mask_reg;
   logic [WIDTH-1:0] analog_input_disable_reg;
   logic             armed_reg;
   logic             ack_reg;
   logic [`WB_DAT_W-1:0] dat_reg;

   // per-pin resolved signals
   logic [WIDTH-1:0] pu_en_eff;
   logic [WIDTH-1:0] pu_val_eff;
   logic [WIDTH-1:0] dd_en_eff;
   logic [WIDTH-1:0] dd_val_eff;
   logic [WIDTH-1:0] pv_en_eff;
   logic [WIDTH-1:0] pv_val_eff;
   logic [WIDTH-1:0] ie_en_eff;
   logic [WIDTH-1:0] ie_val_eff;
   logic [WIDTH-1:0] tog_eff;
   logic [WIDTH-1:0] pc_armed;
   logic [WIDTH-1:0] oe_c;
   logic [WIDTH-1:0] out_c;
   logic [WIDTH-1:0] pu_c;
   logic [WIDTH-1:0] din_c;
   logic [WIDTH-1:0] pin_sample_bit;

   // shared port strobes
   logic             bus_req;
   logic             bus_wr;
   reg_sel_e         wr_sel;
   logic             port_latch_write_strobe;
   logic             pin_toggle_write_strobe;
   logic             direction_write_strobe;
   logic             control_write_strobe;
   logic             pc_mask_write_strobe;
   logic             analog_dis_write_strobe;
   logic [WIDTH-1:0] wdat;

   // address decode, shared by the write and read paths
   function automatic reg_sel_e decode_adr(input logic [`WB_ADR_W-1:0] a);
      reg_sel_e s;
      s = sel_none;
      unique case (a)
         `OFS_PIN_SAMPLE: s = sel_pin;
         `OFS_DIRECTION:  s = sel_dir;
         `OFS_LATCH:      s = sel_latch;
         `OFS_CONTROL:    s = sel_ctrl;
         `OFS_PC_MASK:    s = sel_pcmask;
         `OFS_ANALOG_DIS: s = sel_adis;
         `OFS_OVR_STATUS: s = sel_status;
         default:         s = sel_none;
      endcase
      return s;
   endfunction

   // widen a port-sized value onto the data bus
   function automatic logic [`WB_DAT_W-1:0] widen(input logic [WIDTH-1:0] v);
      logic [`WB_DAT_W-1:0] w;
      w = '0;
      w[WIDTH-1:0] = v;
      return w;
   endfunction

   // read multiplexer; unmapped offsets read as zero
   function automatic logic [`WB_DAT_W-1:0] read_value(input reg_sel_e s);
      logic [`WB_DAT_W-1:0] r;
      r = '0;
      unique case (s)
         sel_pin:    r = widen(pin_sample_bit);
         sel_dir:    r = widen(direction_reg);
         sel_latch:  r = widen(latch_reg);
         sel_ctrl: begin
            r[`CTRL_PUD_BIT]  = global_pullup_disable_reg;
            r[`CTRL_PCIE_BIT] = pin_change_group0_en_reg;
         end
         sel_pcmask: r = widen(pc_mask_reg);
         sel_adis:   r = widen(analog_input_disable_reg);
         sel_status: r = widen(pad_oe_o);
         sel_none:   r = '0;
      endcase
      return r;
   endfunction

   // writes land on the edge where the master sees ack
   assign bus_req = cyc_i & stb_i;
   assign bus_wr  = bus_req & we_i & ack_reg & sel_i[0];
   assign wr_sel  = decode_adr(adr_i);
   assign wdat    = dat_i[WIDTH-1:0];

   // one strobe per register, common to every pin of the port
   assign port_latch_write_strobe = bus_wr & (wr_sel == sel_latch);  // [R12]
   assign pin_toggle_write_strobe = bus_wr & (wr_sel == sel_pin);    // [R12]
   assign direction_write_strobe  = bus_wr & (wr_sel == sel_dir);    // [R12]
   assign control_write_strobe    = bus_wr & (wr_sel == sel_ctrl);
   assign pc_mask_write_strobe    = bus_wr & (wr_sel == sel_pcmask);
   assign analog_dis_write_strobe = bus_wr & (wr_sel == sel_adis);

   // single-cycle ack; dropping it each time ends back-to-back retriggers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else if (ce_i) begin
         ack_reg <= bus_req & ~ack_reg;
      end
   end

   // read data captured with the ack so it stands while ack is high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_reg <= '0;
      end else if (ce_i && bus_req && !ack_reg) begin
         dat_reg <= we_i ? '0 : read_value(wr_sel);
      end
   end

   assign ack_o = ack_reg;
   assign dat_o = dat_reg;

   // overrides stay dead through reset and one cycle beyond
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         armed_reg <= 1'b0;                                    // [R18]
      end else if (ce_i) begin
         armed_reg <= 1'b1;                                    // [R18]
      end
   end

   // direction register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         direction_reg <= {WIDTH{`RST_DIRECTION}};
      end else if (ce_i && direction_write_strobe) begin
         direction_reg <= wdat;                                // [R15]
      end
   end

   // latch: write first, then software toggle, then module toggle
   always_comb begin
      latch_next = latch_reg;
      if (port_latch_write_strobe) begin
         latch_next = wdat;
      end
      if (pin_toggle_write_strobe) begin
         latch_next = latch_next ^ wdat;
      end
      latch_next = latch_next ^ tog_eff;                       // [R7]
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_reg <= {WIDTH{`RST_LATCH}};
      end else if (ce_i) begin
         latch_reg <= latch_next;
      end
   end

   // control bits shared by every pin of this port
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         global_pullup_disable_reg <= `RST_PUD;
         pin_change_group0_en_reg  <= `RST_PCIE;
      end else if (ce_i && control_write_strobe) begin
         global_pullup_disable_reg <= dat_i[`CTRL_PUD_BIT];    // [R12]
         pin_change_group0_en_reg  <= dat_i[`CTRL_PCIE_BIT];
      end
   end

   // pin-change mask and analog input disable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_mask_reg              <= {WIDTH{`RST_PC_MASK}};
         analog_input_disable_reg <= {WIDTH{`RST_ANALOG_DIS}};
      end else if (ce_i) begin
         if (pc_mask_write_strobe) begin
            pc_mask_reg <= wdat;
         end
         if (analog_dis_write_strobe) begin
            analog_input_disable_reg <= wdat;
         end
      end
   end

   // pin-change enabled per pin when both mask and group enable are set
   assign pc_armed = pc_mask_reg & {WIDTH{pin_change_group0_en_reg}};

   // override sources: fixed mapping on the first port except toggle, which comes from modules on every port; modules elsewhere
   always_comb begin
      tog_eff = toggle_override_en_i & {WIDTH{armed_reg}};       // [R13] [R18]
      if (FIRST_PORT) begin
         pu_en_eff  = '0;                                         // [R17]
         pu_val_eff = '0;                                         // [R17]
         dd_en_eff  = '0;                                         // [R17]
         dd_val_eff = '0;                                         // [R17]
         pv_en_eff  = '0;                                         // [R17]
         pv_val_eff = '0;                                         // [R17]
         ie_en_eff  = (pc_armed | analog_input_disable_reg)
                      & {WIDTH{armed_reg}};                       // [R17] [R18]
         ie_val_eff = pc_armed;                                   // [R17]
      end else begin
         pu_en_eff  = pullup_override_en_i & {WIDTH{armed_reg}};  // [R18]
         pu_val_eff = pullup_override_val_i;
         dd_en_eff  = dir_override_en_i & {WIDTH{armed_reg}};     // [R18]
         dd_val_eff = dir_override_val_i;
         pv_en_eff  = value_override_en_i & {WIDTH{armed_reg}};   // [R18]
         pv_val_eff = value_override_val_i;
         ie_en_eff  = input_en_override_en_i & {WIDTH{armed_reg}};// [R18]
         ie_val_eff = input_en_override_val_i;
      end
   end

   // one resolver per pin keeps every override separate
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      pin_override_cell u_cell (
         .clk_i       (clk_i),
         .rst_i       (rst_i),
         .ce_i        (ce_i),
         .pad_in_i    (pad_in_i[i]),
         .dir_bit_i   (direction_reg[i]),
         .latch_bit_i (latch_reg[i]),
         .pud_i       (global_pullup_disable_reg),
         .sleep_i     (sleep_i),
         .pu_en_i     (pu_en_eff[i]),
         .pu_val_i    (pu_val_eff[i]),
         .dd_en_i     (dd_en_eff[i]),
         .dd_val_i    (dd_val_eff[i]),
         .pv_en_i     (pv_en_eff[i]),
         .pv_val_i    (pv_val_eff[i]),
         .ie_en_i     (ie_en_eff[i]),
         .ie_val_i    (ie_val_eff[i]),
         .oe_o        (oe_c[i]),
         .out_o       (out_c[i]),
         .pu_o        (pu_c[i]),
         .din_o       (din_c[i]),
         .sample_o    (pin_sample_bit[i])
      );
   end

   // pad controls registered; reset leaves every pin tri-stated
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pad_oe_o    <= '0;
         pad_out_o   <= '0;
         pullup_en_o <= '0;
      end else if (ce_i) begin
         pad_oe_o    <= oe_c;                                  // [R3]
         pad_out_o   <= out_c;                                 // [R5]
         pullup_en_o <= pu_c;                                  // [R1] [R2]
      end
   end

   // module-side copies; one flop only, so consumers still sync
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alt_digital_in_o     <= '0;
         analog_channel_in_o  <= '0;
         pin_change_irq_src_o <= '0;
      end else if (ce_i) begin
         alt_digital_in_o     <= din_c;                        // [R10]
         analog_channel_in_o  <= pad_in_i;                     // [R11] [R14]
         pin_change_irq_src_o <= din_c & pc_armed;             // [R14]
      end
   end

endmodule
`default_nettype wire

// *** tb/periph_override_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module periph_override_model (
   input  wire logic        clk_i, // port clock
   input  wire logic        rst_i, // sync reset
   input  wire logic        run_i, // peripheral enabled
   input  wire logic [63:0] pat_i, // wanted override pattern
   input  wire logic [7:0]  tog_i, // toggle request, one cycle
   output logic      [63:0] ovr_o, // overrides as presented
   output logic      [7:0]  tog_o  // toggle pulse as presented
);
   // overrides built inside the peripheral, silent until it runs
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         ovr_o <= 64'h0;
         tog_o <= 8'h00;
      end else begin
         ovr_o <= pat_i;
         tog_o <= tog_i;
      end
   end
endmodule

`default_nettype wire

// *** tb/port_pin_override_mux_checker.sv ***
`timescale 1ns/10ps
`default_nettype none

module port_pin_override_mux_checker #(
   parameter int WIDTH      = 8,   // pins in this port
   parameter bit FIRST_PORT = 1'b1 // first port mapping
) (
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             ce_i,
   input wire logic             cyc_i,
   input wire logic             stb_i,
   input wire logic             ack_o,
   input wire logic             sleep_i,
   input wire logic [WIDTH-1:0] pad_in_i,
   input wire logic [WIDTH-1:0] pad_out_o,
   input wire logic [WIDTH-1:0] pad_oe_o,
   input wire logic [WIDTH-1:0] pullup_en_o,
   input wire logic [WIDTH-1:0] pullup_override_en_i,
   input wire logic [WIDTH-1:0] pullup_override_val_i,
   input wire logic [WIDTH-1:0] dir_override_en_i,
   input wire logic [WIDTH-1:0] dir_override_val_i,
   input wire logic [WIDTH-1:0] value_override_en_i,
   input wire logic [WIDTH-1:0] value_override_val_i,
   input wire logic [WIDTH-1:0] input_en_override_en_i,
   input wire logic [WIDTH-1:0] input_en_override_val_i,
   input wire logic [WIDTH-1:0] alt_digital_in_o,
   input wire logic [WIDTH-1:0] analog_channel_in_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [2:0] live_reg;
   logic       live;
   // three clean enabled edges: arming settled, so no false fire after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) live_reg <= 3'b000;
      else live_reg <= {live_reg[1:0], ce_i};
   end
   assign live = (live_reg == 3'b111) && !FIRST_PORT;

   chk_pu_override: assert property (live |-> ((pullup_en_o ^ $past(pullup_override_val_i))
      & $past(pullup_override_en_i)) == '0) else $error("pull-up ignores its override");
   chk_dir_override: assert property (live |-> ((pad_oe_o ^ $past(dir_override_val_i))
      & $past(dir_override_en_i)) == '0) else $error("driver enable ignores its override");
   chk_val_override: assert property (live |-> (pad_oe_o & $past(value_override_en_i)
      & (pad_out_o ^ $past(value_override_val_i))) == '0) else $error("value override lost");
   chk_out_quiet: assert property ((pad_out_o & ~pad_oe_o) == '0)
      else $error("value driven with driver off");
   chk_ie_override: assert property (live |-> ((alt_digital_in_o ^ ($past(pad_in_i)
      & $past(input_en_override_val_i))) & $past(input_en_override_en_i)) == '0)
      else $error("input enable ignores its override");
   chk_sleep_clamp: assert property (live && $past(sleep_i) |->
      (alt_digital_in_o & ~$past(input_en_override_en_i)) == '0) else $error("input not clamped");
   chk_awake_input: assert property (live && !$past(sleep_i) |-> ((alt_digital_in_o
      ^ $past(pad_in_i)) & ~$past(input_en_override_en_i)) == '0) else $error("input lost");
   chk_analog_copy: assert property (live_reg[0] |-> analog_channel_in_o == $past(pad_in_i))
      else $error("analog path differs from pad");
   chk_reset_quiet: assert property ($past(rst_i) |-> pad_oe_o == '0 && pullup_en_o == '0
      && pad_out_o == '0) else $error("pin active right after reset");
   chk_ack_once: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o
      ##1 (!ack_o || !$past(ce_i))) else $error("bus ack not a single pulse");

   cover property (pullup_override_en_i != '0 ##1 pullup_en_o != '0);
   cover property (sleep_i && alt_digital_in_o != '0);
   cover property (cyc_i && stb_i ##1 ack_o);
endmodule

bind port_pin_override_mux port_pin_override_mux_checker #(.WIDTH(WIDTH), .FIRST_PORT(FIRST_PORT))
   chk_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .ack_o(ack_o), .sleep_i(sleep_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
   .pad_oe_o(pad_oe_o), .pullup_en_o(pullup_en_o), .pullup_override_en_i(pullup_override_en_i),
   .pullup_override_val_i(pullup_override_val_i), .dir_override_en_i(dir_override_en_i),
   .dir_override_val_i(dir_override_val_i), .value_override_en_i(value_override_en_i),
   .value_override_val_i(value_override_val_i), .input_en_override_en_i(input_en_override_en_i),
   .input_en_override_val_i(input_en_override_val_i), .alt_digital_in_o(alt_digital_in_o),
   .analog_channel_in_o(analog_channel_in_o));

`default_nettype wire

// *** tb/port_pin_override_mux_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module port_pin_override_mux_tb;
   import port_pin_override_pkg::*;
   logic        clk_i = 0, rst_i = 1, ce_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, sleep_i = 0;
   logic        ack_o, run = 0;
   logic [7:0]  adr_i = 0, pad_in_i = 0, tog = 0, tog_o, oe_o, out_o, pu_o, din_o, ana_o, pc_o;
   logic [7:0]  dir, lat, msk, pe, pv, de, dv, ve, vv, ie, iv;
   logic [1:0]  ctl;
   logic [3:0]  sel_i = 0;
   logic [31:0] dat_i = 0, dat_o, q, r;
   logic [63:0] pat = 64'h0123456789abcdef, ovr;
   logic [7:0]  offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
   int          err_total = 0, n_compared = 0, seed = 32'h5b9bbdda;

   // 4 ns clock
   always #2 clk_i = ~clk_i;
   assign {iv, ie, vv, ve, dv, de, pv, pe} = pat;

   periph_override_model mdl_u (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .pat_i(pat),
      .tog_i(tog), .ovr_o(ovr), .tog_o(tog_o));
   port_pin_override_mux #(.WIDTH(8), .FIRST_PORT(1'b0)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(ce_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .sleep_i(sleep_i), .pad_in_i(pad_in_i),
      .pad_out_o(out_o), .pad_oe_o(oe_o), .pullup_en_o(pu_o),
      .pullup_override_en_i(ovr[7:0]), .pullup_override_val_i(ovr[15:8]),
      .dir_override_en_i(ovr[23:16]), .dir_override_val_i(ovr[31:24]),
      .value_override_en_i(ovr[39:32]), .value_override_val_i(ovr[47:40]),
      .toggle_override_en_i(tog_o), .input_en_override_en_i(ovr[55:48]),
      .input_en_override_val_i(ovr[63:56]), .alt_digital_in_o(din_o),
      .analog_channel_in_o(ana_o), .pin_change_irq_src_o(pc_o));

   // expected pin levels from the bench's own copy of registers and overrides
   function automatic logic [7:0] f_oe();
      return (de & dv) | (~de & dir);
   endfunction
   function automatic logic [7:0] f_out();
      return f_oe() & ((ve & vv) | (~ve & lat));
   endfunction
   function automatic logic [7:0] f_pu();
      return (pe & pv) | (~pe & ~dir & lat & {8{~ctl[0]}});
   endfunction
   function automatic logic [7:0] f_din();
      return pad_in_i & ((ie & iv) | (~ie & {8{~sleep_i}}));
   endfunction

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk_pins(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // classic wishbone cycle; request held until ack is sampled, no latency assumed
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] rd);
      int n;
      @(posedge clk_i);
      adr_i <= a;
      we_i  <= w;
      dat_i <= d;
      sel_i <= 4'h1;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) begin
         chk_reg("wb_ack", 32'h1, 32'h0);
         finish_test();
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      chk_pins("reset_oe", 8'h00, oe_o);
      chk_pins("reset_pullup", 8'h00, pu_o);
      foreach (offs[k]) begin
         wb(offs[k], 1'b0, 32'h0, q);
         chk_reg("reset_value", 32'h0, q);
      end
      wb(8'h1c, 1'b1, 32'hff, q);
      wb(8'h1c, 1'b0, 32'h0, q);
      chk_reg("unmapped", 32'h0, q);
      $display("test reset_values done");
      run <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         r = $random(seed);
         {ctl, msk, lat, dir} = r[25:0];
         sleep_i <= r[26];
         pad_in_i <= r[31:27] ^ r[7:0];
         // corners first: all overrides low, all high, none
         pat <= (i == 0) ? {4{16'h00ff}} : (i == 1) ? '1 : (i == 2) ? 64'h0
                : {$random(seed), $random(seed)};
         wb(8'h04, 1'b1, {24'h0, dir}, q);
         wb(8'h08, 1'b1, {24'h0, lat}, q);
         wb(8'h0c, 1'b1, {30'h0, ctl}, q);
         wb(8'h10, 1'b1, {24'h0, msk}, q);
         repeat (8) @(posedge clk_i);
         chk_pins("pad_oe", f_oe(), oe_o);
         chk_pins("pad_out", f_out(), out_o);
         chk_pins("pullup", f_pu(), pu_o);
         chk_pins("alt_in", f_din(), din_o);
         chk_pins("pc_src", f_din() & msk & {8{ctl[1]}}, pc_o);
         chk_pins("analog", pad_in_i, ana_o);
         wb(8'h18, 1'b0, 32'h0, q);
         chk_reg("status", {24'h0, f_oe()}, q);
         wb(8'h00, 1'b0, 32'h0, q);
         chk_reg("pin_sample", {24'h0, f_din()}, q);
         r = $random(seed);
         wb(8'h00, 1'b1, {24'h0, r[7:0]}, q);
         lat = lat ^ r[7:0] ^ r[15:8];
         tog <= r[15:8];
         @(posedge clk_i);
         tog <= 8'h00;
         wb(8'h08, 1'b0, 32'h0, q);
         chk_reg("latch", {24'h0, lat}, q);
      end
      $display("test random_pins done");
      q = {24'h0, f_oe()};
      ce_i <= 1'b0;
      pat <= ~pat;
      repeat (4) @(posedge clk_i);
      chk_pins("frozen_oe", q[7:0], oe_o);
      ce_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk_pins("resumed_oe", f_oe(), oe_o);
      $display("test clock_enable done");
      finish_test();
   end
endmodule

`default_nettype wire
